/* pkg/frrc_defines.vh */
`ifndef FRRC_DEFINES_VH
`define FRRC_DEFINES_VH

// Response mode field of the reaction byte.
`define FRRC_RESP_HI 7
`define FRRC_RESP_LO 6
`define FRRC_RESP_IGNORE 2'h0
`define FRRC_RESP_RUN_DELAY 2'h1
`define FRRC_RESP_RETRY 2'h2
`define FRRC_RESP_LATCH 2'h3

// Retry count field.
`define FRRC_RETRY_HI 5
`define FRRC_RETRY_LO 3
`define FRRC_RETRY_NONE 3'h0
`define FRRC_RETRY_ENDLESS 3'h7

// Retry and delay time field.
`define FRRC_TIME_HI 2
`define FRRC_TIME_LO 0

// Reaction byte reset value.
`define FRRC_CFG_RESET 8'h00

// Time unit select codes.
`define FRRC_UNIT_1MS 2'h0
`define FRRC_UNIT_10MS 2'h1
`define FRRC_UNIT_100MS 2'h2
`define FRRC_UNIT_1S 2'h3

// Time figures in microseconds and the clock rate in MHz.
`define FRRC_CLK_MHZ 250
`define FRRC_T_1MS_US 1000
`define FRRC_T_10MS_US 10000
`define FRRC_T_100MS_US 100000
`define FRRC_T_1S_US 1000000

// Cycles per time unit, derived from the figures above.
`define FRRC_CYC_1MS (`FRRC_T_1MS_US * `FRRC_CLK_MHZ)
`define FRRC_CYC_10MS (`FRRC_T_10MS_US * `FRRC_CLK_MHZ)
`define FRRC_CYC_100MS (`FRRC_T_100MS_US * `FRRC_CLK_MHZ)
`define FRRC_CYC_1S (`FRRC_T_1S_US * `FRRC_CLK_MHZ)

// Widths of the unit and unit-count counters.
`define FRRC_TICK_W 28
`define FRRC_CNT_W 8

`endif

/* rtl/frrc_cfg_reg.v */
`default_nettype none
`include "frrc_defines.vh"

// Holds the reaction byte; read data comes out of a register.
module frrc_cfg_reg
(
   // Clock and reset.
   input wire clock_i,
   input wire rst_i,
   // Write and read port.
   input wire wr_en_i,
   input wire [7:0] wr_data_i,
   output reg [7:0] rd_data_o
);

   // The byte is held in the read register itself, so reads never lag a write.
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         rd_data_o <= `FRRC_CFG_RESET;
      end
      else if (wr_en_i)
      begin
         rd_data_o <= wr_data_i;
      end
   end

endmodule // frrc_cfg_reg
`default_nettype wire

/* rtl/frrc_fault_ctrl.v */
// How it works
// - Retry codes 2..6 give that many restarts.
// - Retries used up: output off until cleared or until another fault's shutdown.
// - Attempt spacing is decoded count times unit.
// - Code 111 retries forever until off.
// - Time field n decodes to 2**n units.
// - Count is run-on delay or retry spacing.
// - Unit length comes from separate unit register.
// - Mode: ignore, run-on, retry, latch off.
// - Code 000 no restart, 001 one restart.
// - Clear, reset, off-on or bias loss clears.
// - Unit is 1 ms, 10 ms, 100 ms, 1 s.
`default_nettype none
`include "frrc_defines.vh"

module frrc_fault_ctrl
(
   // Clock and reset.
   input wire clock_i,
   input wire rst_i,
   // Reaction byte access from the command decoder.
   input wire cfg_wr_i,
   input wire [7:0] cfg_wdata_i,
   output wire [7:0] cfg_rdata_o,
   // Input voltage unit select, bits 5:4 of the unit register.
   input wire [1:0] unit_sel_i,
   // Warning level from the input monitor, asynchronous.
   input wire fault_i,
   // Clear sources: bit clear, clear-all command, on/off command, bias good.
   input wire clear_bit_i,
   input wire clear_all_i,
   input wire on_cmd_i,
   input wire bias_ok_i,
   // Another fault forcing shutdown.
   input wire other_shutdown_i,
   // Power stage enable and status.
   output reg out_en_o,
   output reg latched_o,
   output reg [2:0] attempts_o
);

   localparam S_RUN = 5'h01;
   localparam S_DELAY = 5'h02;
   localparam S_WAIT = 5'h04;
   localparam S_TRY = 5'h08;
   localparam S_OFF = 5'h10;

   reg [4:0] state;
   reg [4:0] next_state;
   reg fault_m;
   reg fault_s;
   reg on_q;
   reg [`FRRC_TICK_W-1:0] tick;
   reg [`FRRC_CNT_W-1:0] units;
   reg [2:0] next_attempts;
   reg timer_go;
   wire [7:0] cfg;
   wire [1:0] mode;
   wire [2:0] retries;
   wire clear;
   wire unit_done;
   wire time_done;
   wire retry_left;

   // Cycles in one time unit for the selected code.
   // The products are 32-bit integers; the longest unit still fits the tick width.
   function [`FRRC_TICK_W-1:0] unit_cycles;
      input [1:0] sel;
      reg [31:0] full;
      begin
         case (sel)
            `FRRC_UNIT_1MS: full = `FRRC_CYC_1MS;
            `FRRC_UNIT_10MS: full = `FRRC_CYC_10MS;
            `FRRC_UNIT_100MS: full = `FRRC_CYC_100MS;
            default: full = `FRRC_CYC_1S;
         endcase
         unit_cycles = full[`FRRC_TICK_W-1:0];
      end
   endfunction

   // Number of units for a time field value n, which is 2 to the n.
   function [`FRRC_CNT_W-1:0] unit_count;
      input [2:0] n;
      begin
         unit_count = 8'h01 << n;
      end
   endfunction

   frrc_cfg_reg u_cfg
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .wr_en_i(cfg_wr_i),
      .wr_data_i(cfg_wdata_i),
      .rd_data_o(cfg)
   );

   assign cfg_rdata_o = cfg;
   assign mode = cfg[`FRRC_RESP_HI:`FRRC_RESP_LO];
   assign retries = cfg[`FRRC_RETRY_HI:`FRRC_RETRY_LO];

   // Any clear source; an on command rising after off is the off-on cycle.
   assign clear = clear_bit_i | clear_all_i | ~bias_ok_i | (on_cmd_i & ~on_q);

   // Retries remain while below the code, and always for the endless code.
   assign retry_left = (retries == `FRRC_RETRY_ENDLESS) |
      (attempts_o < retries);

   assign unit_done = (tick == unit_cycles(unit_sel_i) - 28'h1);
   assign time_done = unit_done & (units == unit_count(cfg[`FRRC_TIME_HI:`FRRC_TIME_LO]) - 8'h01);

   // The warning comes from the analogue side, so it is synchronised first.
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         fault_m <= 1'b0;
         fault_s <= 1'b0;
         on_q <= 1'b1;
      end
      else
      begin
         fault_m <= fault_i;
         fault_s <= fault_m;
         on_q <= on_cmd_i;
      end
   end

   // Delay timer; one timer serves run-on delay and retry spacing alike.
   // It restarts when a span ends, so a retry wait that follows a run-on delay
   // directly begins from zero instead of counting on from the old span.
   always @(posedge clock_i)
   begin
      if (rst_i | ~timer_go | time_done)
      begin
         tick <= {`FRRC_TICK_W{1'b0}};
         units <= {`FRRC_CNT_W{1'b0}};
      end
      else if (unit_done)
      begin
         tick <= {`FRRC_TICK_W{1'b0}};
         units <= units + 8'h01;
      end
      else
      begin
         tick <= tick + 28'h1;
      end
   end

   // Next state; a shutdown by another fault or an off command always wins.
   always @*
   begin
      next_state = state;
      next_attempts = attempts_o;
      timer_go = 1'b0;
      case (state)
         S_RUN:
         begin
            if (fault_s & ~clear)
            begin
               case (mode)
                  `FRRC_RESP_IGNORE: next_state = S_RUN;
                  `FRRC_RESP_RUN_DELAY: next_state = S_DELAY;
                  `FRRC_RESP_RETRY: next_state = retry_left ? S_WAIT : S_OFF;
                  default: next_state = S_OFF;
               endcase
            end
         end
         S_DELAY:
         begin
            timer_go = 1'b1;
            if (~fault_s | clear)
            begin
               next_state = S_RUN;
            end
            else if (time_done)
            begin
               next_state = retry_left ? S_WAIT : S_OFF;
            end
         end
         S_WAIT:
         begin
            timer_go = 1'b1;
            if (clear)
            begin
               next_state = S_RUN;
               next_attempts = 3'h0;
            end
            else if (time_done)
            begin
               next_state = S_TRY;
               next_attempts = (attempts_o == 3'h7) ? attempts_o : attempts_o + 3'h1;
            end
         end
         S_TRY:
         begin
            // One cycle with output on, then check whether the fault is gone.
            if (~fault_s | clear)
            begin
               next_state = S_RUN;
               next_attempts = 3'h0;
            end
            else
            begin
               next_state = retry_left ? S_WAIT : S_OFF;
            end
         end
         S_OFF:
         begin
            if (clear)
            begin
               next_state = S_RUN;
               next_attempts = 3'h0;
            end
         end
         default:
         begin
            next_state = S_RUN;
         end
      endcase
      if (other_shutdown_i | ~on_cmd_i)
      begin
         next_state = S_RUN;
         next_attempts = 3'h0;
      end
   end

   // State and registered outputs; the stage is off while waiting or latched.
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state <= S_RUN;
         attempts_o <= 3'h0;
         out_en_o <= 1'b0;
         latched_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         attempts_o <= next_attempts;
         out_en_o <= on_cmd_i & ~other_shutdown_i &
            ((next_state == S_RUN) | (next_state == S_DELAY) | (next_state == S_TRY));
         latched_o <= (next_state == S_OFF);
      end
   end

endmodule // frrc_fault_ctrl
`default_nettype wire

/* sim/frrc_asserts.sv */
`default_nettype none
module frrc_asserts
(
   // Clock, reset, register.
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic [7:0] cfg_rdata_o,
   // Fault, clear and control.
   input wire logic fault_i,
   input wire logic clear_bit_i,
   input wire logic clear_all_i,
   input wire logic on_cmd_i,
   input wire logic bias_ok_i,
   input wire logic other_shutdown_i,
   // Stage status.
   input wire logic out_en_o,
   input wire logic latched_o,
   input wire logic [2:0] attempts_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire hold;
   // A held fault in a shutdown mode with nothing else disturbing the state.
   assign hold = fault_i && cfg_rdata_o[7] && on_cmd_i && bias_ok_i && !other_shutdown_i
      && !clear_bit_i && !clear_all_i && !cfg_wr_i;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_cfg_echo: assert property (cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
      else $error("reaction byte not stored");
   a_off_cmd: assert property (!on_cmd_i |=> !out_en_o)
      else $error("enabled while off");
   a_other_off: assert property (other_shutdown_i |=> !out_en_o)
      else $error("enabled under other fault");
   a_latch_off: assert property (latched_o |-> !out_en_o)
      else $error("enabled while latched");
   a_clear_count: assert property (clear_all_i |=> attempts_o == 3'h0)
      else $error("attempts kept after clear");
   a_bias_clear: assert property (!bias_ok_i |=> !latched_o)
      else $error("latch kept after bias loss");
   a_ignore_run: assert property ((cfg_rdata_o[7:6] == 2'h0 && out_en_o && on_cmd_i
      && !other_shutdown_i && !cfg_wr_i) |=> out_en_o)
      else $error("ignore mode stopped");
   a_shut_mode: assert property ((out_en_o && hold) ##1 hold [*3] |=> !out_en_o)
      else $error("no shutdown on fault");
endmodule // frrc_asserts
bind frrc_fault_ctrl frrc_asserts u_chk (.clock_i, .rst_i, .cfg_wr_i, .cfg_wdata_i,
   .cfg_rdata_o, .fault_i, .clear_bit_i, .clear_all_i, .on_cmd_i, .bias_ok_i,
   .other_shutdown_i, .out_en_o, .latched_o, .attempts_o);
`default_nettype wire

/* sim/frrc_host.sv */
`default_nettype none
module frrc_host
(
   // Clock.
   input wire logic clock_i,
   // Reaction byte write.
   output logic cfg_wr_o,
   output logic [7:0] cfg_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle data is scrambled so a stale byte is never taken by accident.
   initial
   begin
      cfg_wr_o = 1'b0;
      cfg_wdata_o = 8'h00;
   end
   // One-cycle write strobe, changed at the falling edge only.
   task wr(input logic [7:0] v);
      @(negedge clock_i);
      cfg_wr_o = 1'b1;
      cfg_wdata_o = v;
      @(negedge clock_i);
      cfg_wr_o = 1'b0;
      cfg_wdata_o = ~v;
   endtask
endmodule // frrc_host
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic fault_i = 1'b0;
   logic clear_bit_i = 1'b0;
   logic clear_all_i = 1'b0;
   logic on_cmd_i = 1'b1;
   logic bias_ok_i = 1'b1;
   logic other_shutdown_i = 1'b0;
   logic [1:0] unit_sel_i = 2'h0;
   logic cfg_wr_i;
   logic [7:0] cfg_wdata_i;
   logic [7:0] cfg_rdata_o;
   logic out_en_o;
   logic latched_o;
   logic [2:0] attempts_o;
   int err_count = 0;
   int checked = 0;
   // Reaction bytes and the {enable, latched} expected a few cycles into a fault.
   logic [7:0] cfg_tab [7] = '{8'h00, 8'h41, 8'h81, 8'h89, 8'hc0, 8'hb8, 8'h90};
   logic [1:0] exp_tab [7] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
   // Clock at 4 ns.
   always #2 clock_i = ~clock_i;
   frrc_host u_host (.clock_i(clock_i), .cfg_wr_o(cfg_wr_i), .cfg_wdata_o(cfg_wdata_i));
   frrc_fault_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .unit_sel_i(unit_sel_i),
      .fault_i(fault_i), .clear_bit_i(clear_bit_i), .clear_all_i(clear_all_i),
      .on_cmd_i(on_cmd_i), .bias_ok_i(bias_ok_i), .other_shutdown_i(other_shutdown_i),
      .out_en_o(out_en_o), .latched_o(latched_o), .attempts_o(attempts_o));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 8.5 microseconds.
   initial
   begin
      #20000;
      err_count++;
      print_verdict;
   end
   // Each mode row is cleared by the next of the four sources in turn.
   // The clear waits until the fault has left the synchroniser, otherwise
   // the stale warning would trip the controller again right after the clear.
   initial
   begin
      repeat (3) @(negedge clock_i);
      rst_i = 1'b0;
      chk(cfg_rdata_o, 8'h00);
      @(negedge clock_i);
      chk({7'h0, out_en_o}, 8'h01);
      for (int i = 0; i < 7; i++)
      begin
         u_host.wr(cfg_tab[i]);
         chk(cfg_rdata_o, cfg_tab[i]);
         fault_i = 1'b1;
         repeat (8) @(negedge clock_i);
         chk({6'h0, out_en_o, latched_o}, {6'h0, exp_tab[i]});
         fault_i = 1'b0;
         repeat (3) @(negedge clock_i);
         chk({6'h0, out_en_o, latched_o}, {6'h0, exp_tab[i]});
         clear_all_i = (i % 4 == 0);
         clear_bit_i = (i % 4 == 1);
         bias_ok_i = (i % 4 != 2);
         on_cmd_i = (i % 4 != 3);
         @(negedge clock_i);
         clear_all_i = 1'b0;
         clear_bit_i = 1'b0;
         bias_ok_i = 1'b1;
         on_cmd_i = 1'b1;
         repeat (4) @(negedge clock_i);
         chk({3'h0, out_en_o, latched_o, attempts_o}, 8'h10);
      end
      // No restart may come before one full unit, 250000 cycles at the shortest.
      unit_sel_i = 2'h1;
      u_host.wr(8'h88);
      fault_i = 1'b1;
      repeat (2000) @(negedge clock_i);
      chk({3'h0, out_en_o, latched_o, attempts_o}, 8'h00);
      fault_i = 1'b0;
      other_shutdown_i = 1'b1;
      repeat (2) @(negedge clock_i);
      chk({3'h0, out_en_o, latched_o, attempts_o}, 8'h00);
      other_shutdown_i = 1'b0;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
